// ==== bench/peewp_dev_model.sv ====
// behavioural byte-wide eeprom with page load, polling and protection
// assumes host pins only; windows shortened to suit the bench
`timescale 1ns/1ps
module peewp_dev_model #(
  parameter real LOAD_NS = 900.0, // byte load window, shortened
  parameter real PROG_NS = 3000.0 // programming time, shortened
) (
  input wire logic [15:0] addr,
  input wire logic [7:0] d_in,
  output logic [7:0] q,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [15:0] cmd_addr [6],
  input wire logic [7:0] cmd_data [6],
  output int viol
);
  logic [7:0] mem [65536];
  logic [15:0] a_lat = 16'h0000;
  logic [8:0] base = 9'h000;
  logic [7:0] last_d = 8'h00, rd_val, held = 8'h00;
  logic busy = 0, tog = 0, prot = 0, win = 0, open = 0, first = 0;
  int idx = 0;
  real t_fall = 0.0, t_end = 0.0;
  wire wr_act = !ce_n && !we_n && oe_n;
  initial begin
    viol = 0;
    foreach (mem[i]) mem[i] = 8'hFF;
  end
  task automatic go_busy();
    busy = 1;
    t_end = $realtime + PROG_NS;
  endtask
  task automatic end_page();
    if (idx == 3) prot = 1;
    idx = 0;
    open = 0;
    win = 0;
    go_busy();
  endtask
  always @(posedge wr_act) begin
    a_lat = addr;
    t_fall = $realtime;
  end
  always @(negedge wr_act) if (!busy && $realtime - t_fall >= 10.0) begin
    last_d = d_in;
    if (idx < 6 && a_lat[14:0] == cmd_addr[idx][14:0] && d_in == cmd_data[idx]) begin
      idx++;
      if (idx == 3) begin
        open = 1;
        first = 1;
      end
      if (idx == 6) begin
        prot = 0;
        open = 0;
        idx = 0;
        go_busy();
      end
    end else begin
      if (idx == 3) begin
        prot = 1;
        win = 1;
      end
      idx = 0;
      if (!prot || win) begin
        if (!open || first) base = a_lat[15:7];
        else if (a_lat[15:7] != base) viol++;
        open = 1;
        first = 0;
        mem[a_lat] = d_in;
      end
    end
  end
  always begin
    #10;
    if (open && $realtime - t_fall > LOAD_NS) end_page();
    if (busy && $realtime >= t_end) busy = 0;
  end
  // reads end a window and toggle while busy
  always @(negedge oe_n) if (!ce_n) begin
    if (open) end_page();
    else idx = 0;
    if (busy) tog = ~tog;
  end
  always @* rd_val = busy ? {~last_d[7], tog, last_d[5:0]} : mem[addr];
  always @(posedge oe_n) held = rd_val;
  // drive only when selected and gated, else a changing level
  assign q = (!ce_n && !oe_n) ? rd_val : ~held;
endmodule

// ==== bench/peewp_host_monitor.sv ====
// checker on the eeprom host request side and pins
// assumes a bind onto peewp_host, ports only
`timescale 1ns/1ps
module peewp_host_monitor (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic req_valid,
  input wire peewp_pkg::peewp_op_t req_op,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic [peewp_pkg::ADDR_W-1:0] byte_address,
  input wire logic [peewp_pkg::DATA_W-1:0] data_pins_o,
  input wire logic data_pins_oe,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n
);
  import peewp_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // gate and select low for the first eight cycles, gate still low 23 cycles later
  sequence s_gate_low;
    (!oe_n && !ce_n) [*8] ##23 !oe_n;
  endsequence
  // gate rises, then select one cycle later
  sequence s_read_close;
    $rose(oe_n) ##1 ce_n;
  endsequence
  AST_NO_CONTEND: assert property (data_pins_oe |-> oe_n)
    else $error("host drove data with gate low");
  AST_WRITE_GATE: assert property (!we_n |-> oe_n && !ce_n)
    else $error("strobe low outside a write");
  AST_STROBE_WIDTH: assert property ($fell(we_n) |-> (!we_n) [*3])
    else $error("strobe pulse too short");
  AST_WRITE_HOLD: assert property (!we_n && !$past(we_n) |->
    $stable(byte_address) && $stable(data_pins_o))
    else $error("address or data moved in strobe");
  AST_DATA_HELD: assert property ($rose(we_n) |-> $past(data_pins_oe))
    else $error("data not driven at strobe rise");
  AST_READ_WALK: assert property ($fell(oe_n) |-> s_gate_low ##1 s_read_close)
    else $error("read cycle shape wrong");
  AST_TAKE_READ: assert property (req_valid && req_ready && req_op == PEEWP_OP_READ
    |=> !req_ready ##1 !ce_n ##5 $fell(oe_n) ##33 rsp_valid)
    else $error("read did not start on time");
  AST_READY_BUSY: assert property (!ce_n |-> !req_ready)
    else $error("ready high during a pin cycle");
endmodule
bind peewp_host peewp_host_monitor i_mon (.ref_clk, .sys_rst, .req_valid, .req_op,
  .req_ready, .rsp_valid, .byte_address, .data_pins_o, .data_pins_oe, .ce_n, .oe_n, .we_n);

// ==== bench/tb_top.sv ====
// self-checking bench for peewp_host against the eeprom model
// assumes shortened load and poll counts below
`timescale 1ns/1ps
module tb_top;
  import peewp_pkg::*;
  localparam int LW = 200; // load gap, 1 us
  logic ref_clk = 0, sys_rst = 1, req_valid = 0, req_last = 0, req_protected = 0;
  peewp_op_t req_op = PEEWP_OP_READ;
  logic [ADDR_W-1:0] req_addr = 16'h0000, byte_address;
  logic [DATA_W-1:0] req_data = 8'h00, rsp_data, data_pins_o, data_pins_i, dev_q;
  logic [ADDR_W-1:0] cmd_addr [CMD_MAX] = '{16'hD555, 16'h2AAA, 16'h5555, 16'h5555,
    16'h2AAA, 16'h5555};
  logic [DATA_W-1:0] cmd_data [CMD_MAX] = '{8'hAA, 8'h55, 8'hA0, 8'hAA, 8'h55, 8'hA5};
  logic req_ready, rsp_valid, rsp_timeout, data_pins_oe, ce_n, oe_n, we_n;
  int errors = 0, n_checks = 0, viol;
  always #2.5 ref_clk = ~ref_clk;
  assign data_pins_i = data_pins_oe ? data_pins_o : dev_q;
  peewp_host #(.LOAD_WIN(LW), .POLL_LIMIT(2000)) i_dut (.ref_clk, .sys_rst, .req_valid,
    .req_op, .req_addr, .req_data, .req_last, .req_protected, .cmd_addr, .cmd_data,
    .req_ready, .rsp_valid, .rsp_data, .rsp_timeout, .byte_address, .data_pins_o,
    .data_pins_oe, .data_pins_i, .ce_n, .oe_n, .we_n);
  peewp_dev_model #(.LOAD_NS(LW * 5.0)) i_dev (.addr(byte_address),
    .d_in(data_pins_oe ? data_pins_o : ~data_pins_o),
    .q(dev_q), .ce_n, .oe_n, .we_n, .cmd_addr, .cmd_data, .viol);
  task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic close_out();
    if (errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one request, held until taken, then wait for its answer
  task automatic req(peewp_op_t op, logic [15:0] a, logic [7:0] d, logic last, logic prt);
    int n;
    n = 0;
    #1;
    req_op = op;
    req_addr = a;
    req_data = d;
    req_last = last;
    req_protected = prt;
    req_valid = 1'b1;
    do begin @(posedge ref_clk); n++; end while (req_ready !== 1'b1 && n < 9000);
    #1 req_valid = 0;
    do begin @(posedge ref_clk); n++; end
    while (rsp_valid !== 1'b1 && !(rsp_timeout === 1'b1 && req_ready === 1'b1) && n < 9000);
    if (n >= 9000) chk("handshake", 0, 1);
  endtask
  task automatic rd(logic [15:0] a, logic [7:0] exp);
    req(PEEWP_OP_READ, a, 8'h00, 0, 0);
    chk("rsp_data", rsp_data, exp);
  endtask
  task automatic t_byte();
    chk("idle pins", {ce_n, oe_n, we_n, data_pins_oe, req_ready}, 5'b11101);
    req(PEEWP_OP_WRITE, 16'h8001, 8'h35, 1, 0);
    chk("timeout", rsp_timeout, 0);
    rd(16'h8001, 8'h35);
    rd(16'h0001, 8'hFF);
  endtask
  task automatic t_page();
    logic [15:0] pa [4] = '{16'h1280, 16'h1281, 16'h3282, 16'h12FF};
    logic [7:0] pd [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
    for (int i = 0; i < 4; i++) req(PEEWP_OP_WRITE, pa[i], pd[i], i == 3, 0);
    rd(16'h1282, 8'h33);
    rd(16'h12FF, 8'h44);
    chk("page faults", viol, 0);
  endtask
  task automatic t_expire();
    req(PEEWP_OP_WRITE, 16'h0400, 8'h5A, 0, 0);
    req(PEEWP_OP_WRITE, 16'h0401, 8'hA5, 0, 0);
    repeat (LW + 40) @(posedge ref_clk);
    chk("req_ready", req_ready, 0);
    rd(16'h0401, 8'hA5);
  endtask
  task automatic t_prot();
    req(PEEWP_OP_PROTECT, 16'h0000, 8'h00, 0, 0);
    chk("timeout", rsp_timeout, 0);
    req(PEEWP_OP_WRITE, 16'h0010, 8'h12, 1, 0);
    chk("timeout", rsp_timeout, 1);
    req(PEEWP_OP_WRITE, 16'h0020, 8'h66, 1, 1);
    chk("timeout", rsp_timeout, 0);
    rd(16'h0020, 8'h66);
    rd(16'h0010, 8'hFF);
    rd(16'h5555, 8'hFF);
    req(PEEWP_OP_UNPROTECT, 16'h0000, 8'h00, 0, 0);
    chk("timeout", rsp_timeout, 0);
    req(PEEWP_OP_WRITE, 16'h0010, 8'h12, 1, 0);
    rd(16'h0010, 8'h12);
  endtask
  // watchdog well beyond the expected run
  initial begin
    #400000;
    errors++;
    close_out();
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    #1 sys_rst = 0;
    @(posedge ref_clk);
    t_byte();
    t_page();
    t_expire();
    t_prot();
    close_out();
  end
endmodule

// ==== hdl/peewp_cycle.sv ====
// one bus cycle on the eeprom pins: read or single byte write
// assumes pin inputs already synchronised by the caller
`timescale 1ns/1ps
module peewp_cycle (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic start,                    // one-cycle start pulse
  input wire logic is_write,                 // 1 write, 0 read
  input wire logic [peewp_pkg::DATA_W-1:0] rd_pins, // synchronised data pins
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic data_oe,                      // host drives data pins
  output logic [peewp_pkg::DATA_W-1:0] rd_byte,
  output logic done                          // one-cycle pulse
);
  import peewp_pkg::*;
  typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_ACT, CY_HOLD} peewp_cy_t;
  peewp_cy_t st;                             // cycle phase
  logic [7:0] cnt;                           // phase counter
  // phase sequencer; control pins change only from flops
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st <= CY_IDLE;
      cnt <= 8'h00;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      data_oe <= 1'b0;
      rd_byte <= 8'h00;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (st)
        CY_IDLE: begin
          if (start) begin
            st <= CY_SETUP;
            cnt <= 8'(SETUP_CYC);
            ce_n <= 1'b0;            // select first, strobe later
            data_oe <= is_write;
          end
        end
        CY_SETUP: begin
          if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
          end else begin
            st <= CY_ACT;
            // R4: write with gate high; R2: read with gate low
            if (is_write) begin
              // R5: strobe falls last so address is captured here
              we_n <= 1'b0;
              cnt <= 8'(STROBE_CYC);   // R15: well above noise filter
            end else begin
              oe_n <= 1'b0;
              cnt <= 8'(READ_CYC);
            end
          end
        end
        CY_ACT: begin
          if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
          end else begin
            st <= CY_HOLD;
            // R6: strobe rises first, data held stable through it
            we_n <= 1'b1;
            oe_n <= 1'b1;
            if (!is_write) begin
              rd_byte <= rd_pins;
            end
          end
        end
        CY_HOLD: begin
          // R3: device floats once gate and select are high
          ce_n <= 1'b1;
          data_oe <= 1'b0;
          st <= CY_IDLE;
          done <= 1'b1;
        end
      endcase
    end
  end
endmodule

// ==== hdl/peewp_host.sv ====
// host controller for a byte-wide parallel eeprom with software protection
// assumes one device on the pins and a user that waits for req_ready
`timescale 1ns/1ps
module peewp_host #(
  parameter int LOAD_WIN = peewp_pkg::LOAD_WIN_CYC,   // byte load gap limit
  parameter int POLL_LIMIT = peewp_pkg::WRITE_CYCLE_CYC // busy poll timeout
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic req_valid,                          // user request, level
  input wire peewp_pkg::peewp_op_t req_op,
  input wire logic [peewp_pkg::ADDR_W-1:0] req_addr,
  input wire logic [peewp_pkg::DATA_W-1:0] req_data,
  input wire logic req_last,                           // last byte of page
  input wire logic req_protected,                      // precede first write of a page with commands
  input wire logic [peewp_pkg::ADDR_W-1:0] cmd_addr [peewp_pkg::CMD_MAX],
  input wire logic [peewp_pkg::DATA_W-1:0] cmd_data [peewp_pkg::CMD_MAX],
  output logic req_ready,
  output logic rsp_valid,
  output logic [peewp_pkg::DATA_W-1:0] rsp_data,
  output logic rsp_timeout,
  output logic [peewp_pkg::ADDR_W-1:0] byte_address,
  output logic [peewp_pkg::DATA_W-1:0] data_pins_o,
  output logic data_pins_oe,
  input wire logic [peewp_pkg::DATA_W-1:0] data_pins_i,
  output logic ce_n,
  output logic oe_n,
  output logic we_n
);
  import peewp_pkg::*;
  typedef enum logic [2:0] {H_IDLE, H_CMD, H_DATA, H_WAIT, H_POLL, H_DONE} peewp_st_t;
  peewp_st_t st;                          // main state
  logic [DATA_W-1:0] sync1, sync2;        // data pin synchroniser
  logic cy_start, cy_write, cy_done;      // cycle engine handshake
  logic cy_data_oe;
  logic [DATA_W-1:0] cy_byte;
  logic [2:0] cmd_idx, cmd_cnt;           // command progress
  logic [TMR_W-1:0] tmr;                  // gap and poll timer
  logic [DATA_W-1:0] last_byte;           // last written value
  logic [DATA_W-1:0] prev_poll;           // previous polling read
  logic have_prev;
  logic page_open;                        // loads in current page
  // two-flop synchroniser, only sync2 is read
  always_ff @(posedge ref_clk) begin
    sync1 <= data_pins_i;
    sync2 <= sync1;
  end
  peewp_cycle u_cycle (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .start(cy_start),
    .is_write(cy_write),
    .rd_pins(sync2),
    .ce_n(ce_n),
    .oe_n(oe_n),
    .we_n(we_n),
    .data_oe(cy_data_oe),
    .rd_byte(cy_byte),
    .done(cy_done)
  );
  // pin enable mirrors cycle engine; R16: never strobe with gate low
  assign data_pins_oe = cy_data_oe;
  // main sequencer
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st <= H_IDLE;
      req_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      rsp_timeout <= 1'b0;
      byte_address <= 16'h0000;
      data_pins_o <= 8'h00;
      cy_start <= 1'b0;
      cy_write <= 1'b0;
      cmd_idx <= 3'h0;
      cmd_cnt <= 3'h0;
      tmr <= '0;
      last_byte <= 8'h00;
      prev_poll <= 8'h00;
      have_prev <= 1'b0;
      page_open <= 1'b0;
    end else begin
      cy_start <= 1'b0;
      rsp_valid <= 1'b0;
      unique case (st)
        H_IDLE: begin
          // R10: a page load keeps going while gaps stay short
          if (page_open && tmr != '0) begin
            tmr <= tmr - 1'b1;
          end
          // ready drops a cycle before expiry so a request is never taken and then lost
          if (page_open && tmr == TMR_W'(1)) begin
            req_ready <= 1'b0;
          end
          if (page_open && tmr == '0) begin
            // R11: gap expired, device is now programming
            st <= H_POLL;
            req_ready <= 1'b0;
            tmr <= TMR_W'(POLL_LIMIT);
            have_prev <= 1'b0;
          end else if (req_valid && req_ready) begin
            req_ready <= 1'b0;
            rsp_timeout <= 1'b0;
            cmd_idx <= 3'h0;
            unique case (req_op)
              PEEWP_OP_READ: begin
                // R1: full address on the pins; R2: gated read
                byte_address <= req_addr;
                cy_write <= 1'b0;
                cy_start <= 1'b1;
                st <= H_DATA;
              end
              PEEWP_OP_WRITE: begin
                // R19: prefix only on first byte of a protected page
                if (req_protected && !page_open) begin
                  cmd_cnt <= 3'h3;
                  st <= H_CMD;
                end else begin
                  // R17: plain write, no command prefix
                  st <= H_DATA;
                  cy_start <= 1'b1;
                end
                // R9: later bytes reuse the open page address bits
                byte_address <= page_open ?
                  {byte_address[ADDR_W-1:PAGE_LSB], req_addr[PAGE_LSB-1:0]} : req_addr;
                data_pins_o <= req_data;
                last_byte <= req_data;
                cy_write <= 1'b1;
              end
              PEEWP_OP_PROTECT: begin
                // R18: enable sequence alone arms protection
                cmd_cnt <= 3'h3;
                st <= H_CMD;
              end
              PEEWP_OP_UNPROTECT: begin
                // R24: six-write clear
                cmd_cnt <= 3'h6;
                st <= H_CMD;
              end
            endcase
          end
        end
        H_CMD: begin
          // R23: command writes issued back to back; R25: external values
          if (!cy_start && (cy_done || cmd_idx == 3'h0)) begin
            if (cmd_idx == cmd_cnt) begin
              if (req_op == PEEWP_OP_WRITE) begin
                byte_address <= req_addr;
                data_pins_o <= req_data;
                cy_write <= 1'b1;
                cy_start <= 1'b1;
                st <= H_DATA;
              end else begin
                // R24: wait write_cycle_time before normal use
                st <= H_POLL;
                last_byte <= cmd_data[cmd_cnt - 3'h1];
                tmr <= TMR_W'(POLL_LIMIT);
                have_prev <= 1'b0;
              end
            end else if (cmd_idx == 3'h0 || cy_done) begin
              // R20: command bytes only reach command addresses
              // R22: top bit is don't care, drive it low
              byte_address <= {1'b0, cmd_addr[cmd_idx][ADDR_W-2:0]};
              data_pins_o <= cmd_data[cmd_idx];
              cy_write <= 1'b1;
              cy_start <= 1'b1;
              cmd_idx <= cmd_idx + 3'h1;
            end
          end
        end
        H_DATA: begin
          if (cy_done) begin
            if (cy_write) begin
              // R8: more bytes may follow; R21: last ends the page
              page_open <= !req_last;
              tmr <= req_last ? '0 : TMR_W'(LOAD_WIN - 2 * STROBE_CYC);
              if (req_last) begin
                st <= H_POLL;
                tmr <= TMR_W'(POLL_LIMIT);
                have_prev <= 1'b0;
              end else begin
                st <= H_IDLE;
                req_ready <= 1'b1;
                rsp_valid <= 1'b1;
              end
            end else begin
              rsp_data <= cy_byte;
              rsp_valid <= 1'b1;
              st <= H_IDLE;
              // stay busy when an open page has just run out; H_POLL follows but, with cy_write low, starts no poll read and never leaves
              req_ready <= !(page_open && tmr == '0);
            end
          end
        end
        H_POLL: begin
          // R26: no write issued while programming, only polling reads
          page_open <= 1'b0;
          if (tmr != '0) begin
            tmr <= tmr - 1'b1;
          end
          if (!cy_start && !cy_write && cy_done) begin
            prev_poll <= cy_byte;
            have_prev <= 1'b1;
            // R12, R13: done when bit7 true and bit6 stops toggling
            if (cy_byte[POLL_BIT] == last_byte[POLL_BIT] && have_prev &&
                cy_byte[TOGGLE_BIT] == prev_poll[TOGGLE_BIT]) begin
              st <= H_DONE;
            end else if (tmr == '0) begin
              rsp_timeout <= 1'b1;
              st <= H_DONE;
            end else begin
              cy_start <= 1'b1;
            end
          end else if (!cy_start && cy_write && !cy_done) begin
            // first poll read at last written address; launched once only, since a
            // relaunch while the engine is busy could mask its done pulse
            cy_write <= 1'b0;
            cy_start <= 1'b1;
            have_prev <= 1'b0;
          end
        end
        H_DONE: begin
          // R14, R7: device idle again
          rsp_valid <= 1'b1;
          req_ready <= 1'b1;
          st <= H_IDLE;
        end
      endcase
    end
  end
endmodule

// ==== hdl/peewp_pkg.sv ====
// constants and types for the parallel eeprom host controller
// assumes a 200 MHz ref_clk and one byte-wide parallel eeprom on the pins
// Behaviour
// R1: sixteen address lines pick one byte
// R2: read drives data while select and gate low
// R3: device data pins float when select or gate high
// R4: write starts with select, strobe low, gate high
// R5: address taken at later falling edge
// R6: data taken at earlier rising edge
// R7: byte write self-times, about five milliseconds
// R8: page holds two to 128 bytes
// R9: host keeps page address bits fixed
// R10: host loads next byte within 100 us
// R11: programming starts after 100 us idle
// R12: polling read returns inverted bit seven
// R13: bit six toggles on each busy read
// R14: ordinary access resumes after programming
// R15: strobe pulses under ten ns ignored
// R16: no write while gate low or deselected
// R17: delivered unprotected, plain writes accepted
// R18: command sequence sets nonvolatile protection
// R19: host precedes protected writes with commands
// R20: command data never stored in array
// R21: command opens one page, then reprotects
// R22: top address bit ignored in commands
// R23: host issues command writes back to back
// R24: six-write sequence clears protection
// R25: command values supplied from outside
// R26: writes during programming are ignored
package peewp_pkg;
  localparam int CLK_MHZ = 200;                     // ref_clk rate
  localparam int ADDR_W = 16;                       // byte address width
  localparam int DATA_W = 8;                        // byte width
  localparam int PAGE_BYTES = 128;                  // largest page
  localparam int PAGE_LSB = 7;                      // lowest page address bit
  localparam int POLL_BIT = 7;                      // complement poll bit
  localparam int TOGGLE_BIT = 6;                    // toggle poll bit
  localparam int STROBE_NS = 50;                    // strobe low time, above noise filter
  localparam int SETUP_NS = 20;                     // address/data setup before strobe
  localparam int READ_NS = 150;                     // read access allowance
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int READ_CYC = (READ_NS * CLK_MHZ + 999) / 1000;
  localparam int LOAD_WIN_US = 100;                 // byte load window
  localparam int LOAD_WIN_CYC = LOAD_WIN_US * CLK_MHZ; // longest gap, rounded down
  localparam int WRITE_CYCLE_MS = 10;               // write_cycle_time poll limit
  localparam int WRITE_CYCLE_CYC = WRITE_CYCLE_MS * 1000 * CLK_MHZ;
  localparam int TMR_W = 24;                        // timer width
  localparam int CMD_MAX = 6;                       // longest command sequence
  typedef enum logic [1:0] {PEEWP_OP_READ, PEEWP_OP_WRITE, PEEWP_OP_PROTECT,
                            PEEWP_OP_UNPROTECT} peewp_op_t;
endpackage
